/* File: bench/fmtc_host_model.sv */
`default_nettype none

// ==========================================================
// Host processor model: one byte per handshake on the command port.
module fmtc_host_model
(
   // Clock
   input wire logic clk_sys,
   // Main status and result
   input wire logic rqm,
   input wire logic dio,
   input wire logic [7:0] resultByte,
   // Command port
   output logic cmdWrite,
   output logic [7:0] cmdByte,
   output logic resultRead
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cmdWrite = 1'b0;
      cmdByte = 8'h00;
      resultRead = 1'b0;
   end

   // A released data bus shows the inverse so a stale byte is never taken for a fresh one.
   task automatic send(input logic [7:0] b);
      int n;
      n = 0;
      @(posedge clk_sys);
      while (!(rqm === 1'b1 && dio === 1'b0) && n < 50)
      begin
         @(posedge clk_sys);
         n++;
      end
      cmdWrite <= 1'b1;
      cmdByte <= b;
      @(posedge clk_sys);
      cmdWrite <= 1'b0;
      cmdByte <= ~b;
   endtask

   task automatic get(output logic [7:0] v);
      int n;
      n = 0;
      @(posedge clk_sys);
      while (!(rqm === 1'b1 && dio === 1'b1) && n < 50)
      begin
         @(posedge clk_sys);
         n++;
      end
      v = resultByte;
      resultRead <= 1'b1;
      @(posedge clk_sys);
      resultRead <= 1'b0;
   endtask
endmodule // fmtc_host_model

`default_nettype wire

/* File: bench/test_floppy_mode_track_commands.sv */
`default_nettype none

module test_floppy_mode_track_commands;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, softReset, cmdWrite, resultRead, seekDone, isFlag, isDone, rate250, unload;
   logic pumpCorr, precomp, dskPin, intGate, rqm, dio, irq, mts, idx, isEn, extended_track_range, scan_wildcard_disable, pu, rg;
   logic seekFirst, settle, lpAct, pin, rgOut, dcOut, busy;
   logic [1:0] lpp;
   logic [7:0] cmdByte, res, v, cnt;
   int miscompares, n_compared, cyc, k;

   fmtc_core #(.SettleUnitCycles(10), .LowPowerCycles(20)) fmtc_core_inst
   (
      .clk_sys(clk_sys), .rst(rst), .softReset(softReset), .cmdWrite(cmdWrite), .cmdByte(cmdByte),
      .resultRead(resultRead), .resultByte_q(res), .msrRqm_q(rqm), .msrDio_q(dio), .msrBusy_q(busy),
      .driveStatus3(8'hA5), .seekStatus0(8'h25), .seekDone(seekDone), .irq_q(irq),
      .motorTimerScale_q(mts), .lowPowerPolicy_q(lpp), .indexFieldOmit_q(idx), .impliedSeekEnable_q(isEn),
      .extendedTrackRange_q(extended_track_range), .scanWildcardDisable_q(scan_wildcard_disable), .pumpPulseOutputEnable_q(pu),
      .readGateTestEnable_q(rg), .cmdImpliedSeekFlag(isFlag), .impliedSeekDone(isDone), .rate250(rate250),
      .seekFirst_q(seekFirst), .settleBusy_q(settle), .headUnloadExpired(unload), .lowPowerActive_q(lpAct),
      .pumpCorrection(pumpCorr), .precompEnable(precomp), .diskChangePin(dskPin),
      .internalReadGate(intGate), .pumpPrecompPin_q(pin), .readGate_q(rgOut), .diskChange_q(dcOut)
   );

   fmtc_host_model fmtc_host_model_inst
   (
      .clk_sys(clk_sys), .rqm(rqm), .dio(dio), .resultByte(res), .cmdWrite(cmdWrite), .cmdByte(cmdByte),
      .resultRead(resultRead)
   );

   // ==========================================================
   // Clock, watchdog and helpers
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         results();
      end
   end

   task automatic results();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask

   task automatic chkb(input string s, input logic e, input logic g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %b, seen %b", s, e, g);
      end
   endtask

   // Sends the top n bytes of b, first byte in the top eight bits.
   task automatic cmd(input logic [31:0] b, input int n);
      for (int i = 0; i < n; i++)
         fmtc_host_model_inst.send(b[31 - 8 * i -: 8]);
   endtask

   task automatic rd(input string s, input logic [7:0] e);
      fmtc_host_model_inst.get(v);
      chk(s, e, v);
   endtask

   // ==========================================================
   // Tests
   initial
   begin
      {rst, softReset, seekDone, isFlag, isDone, rate250, unload} = 7'h40;
      {pumpCorr, precomp, dskPin, intGate} = 4'hA;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk("mode", 8'h00, {lpp, mts, idx, isEn, extended_track_range, scan_wildcard_disable, pu});
      seekDone <= 1'b1;
      @(posedge clk_sys);
      seekDone <= 1'b0;
      cmd(32'h0401_0000, 2);
      rd("drive status", 8'hA5);
      chkb("irq", 1'b1, irq);
      cmd(32'h0127_2303, 4);
      repeat (3) @(posedge clk_sys);
      chkb("irq", 1'b1, irq);
      chk("mode", 8'hBF, {lpp, mts, idx, isEn, extended_track_range, scan_wildcard_disable, pu});
      chkb("read gate", 1'b1, rg);
      chkb("low power", 1'b1, lpAct);
      chk("pins", 8'h06, {5'h00, pin, rgOut, dcOut});
      isFlag <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chkb("seek first", 1'b1, seekFirst);
      cmd(32'h0800_0000, 1);
      rd("seek status", 8'h25);
      chkb("irq", 1'b0, irq);
      for (k = 0; k < 3; k++)
      begin
         cmd({k == 0 ? 8'h08 : (k == 1 ? 8'hFF : 8'h00), 24'h0}, 1);
         @(posedge clk_sys);
         chk("msr", 8'h07, {5'h00, busy, rqm, dio});
         rd("invalid", 8'h80);
         chkb("irq", 1'b0, irq);
      end
      cmd(32'h0110_2100, 4);
      repeat (3) @(posedge clk_sys);
      chk("mode", 8'h44, {lpp, mts, idx, isEn, extended_track_range, scan_wildcard_disable, pu});
      chkb("low power", 1'b0, lpAct);
      chk("pins", 8'h01, {5'h00, pin, rgOut, dcOut});
      chkb("seek first", 1'b0, seekFirst);
      for (k = 0; k < 2; k++)
      begin
         rate250 <= k[0];
         isDone <= 1'b1;
         @(posedge clk_sys);
         isDone <= 1'b0;
         cnt = 8'h00;
         repeat (60)
         begin
            @(posedge clk_sys);
            cnt += {7'h00, settle};
         end
         chk("settle", k[0] ? 8'h28 : 8'h14, cnt);
      end
      unload <= 1'b1;
      @(posedge clk_sys);
      unload <= 1'b0;
      repeat (15) @(posedge clk_sys);
      chkb("low power", 1'b0, lpAct);
      repeat (10) @(posedge clk_sys);
      chkb("low power", 1'b1, lpAct);
      // Bit 2 selects the high byte whatever the extended range setting.
      for (k = 0; k < 16; k++)
      begin
         cmd({k < 8 ? 8'h61 : 8'h21, 8'(k % 8), k < 8 ? 8'hA0 + 8'(k) : 8'h5C, 8'h00}, 3);
         rd("track", 8'hA0 + 8'(k % 8));
      end
      chkb("irq", 1'b0, irq);
      softReset <= 1'b1;
      @(posedge clk_sys);
      softReset <= 1'b0;
      @(posedge clk_sys);
      chk("mode", 8'h00, {lpp, mts, idx, isEn, extended_track_range, scan_wildcard_disable, pu});
      chkb("read gate", 1'b0, rg);
      results();
   end
endmodule // test_floppy_mode_track_commands

`default_nettype wire

/* File: hdl/fmtc_core.sv */
`default_nettype none

module fmtc_core
   import fmtc_pkg::*;
#(
   parameter int SettleUnitCycles = SETTLE_UNIT_CYCLES,
   parameter int LowPowerCycles = LOW_POWER_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic softReset,
   // Command and result port
   input wire logic cmdWrite,
   input wire logic [7:0] cmdByte,
   input wire logic resultRead,
   output logic [7:0] resultByte_q,
   output logic msrRqm_q,
   output logic msrDio_q,
   output logic msrBusy_q,
   // Status sources and seek interrupt
   input wire logic [7:0] driveStatus3,
   input wire logic [7:0] seekStatus0,
   input wire logic seekDone,
   output logic irq_q,
   // Mode settings
   output logic motorTimerScale_q,
   output logic [1:0] lowPowerPolicy_q,
   output logic indexFieldOmit_q,
   output logic impliedSeekEnable_q,
   output logic extendedTrackRange_q,
   output logic scanWildcardDisable_q,
   output logic pumpPulseOutputEnable_q,
   output logic readGateTestEnable_q,
   // Implied seek and head settle
   input wire logic cmdImpliedSeekFlag,
   input wire logic impliedSeekDone,
   input wire logic rate250,
   output logic seekFirst_q,
   output logic settleBusy_q,
   // Low power
   input wire logic headUnloadExpired,
   output logic lowPowerActive_q,
   // Shared pins
   input wire logic pumpCorrection,
   input wire logic precompEnable,
   input wire logic diskChangePin,
   input wire logic internalReadGate,
   output logic pumpPrecompPin_q,
   output logic readGate_q,
   output logic diskChange_q
);

   // ==========================================================
   // Command sequencer
   fmtc_state_type state_q, state_d;
   fmtc_cmd_type cmd_q, cmd_d;
   logic [1:0] argLeft_q, argLeft_d;
   logic [1:0] argIdx_q, argIdx_d;
   logic trackWrite_q, trackWrite_d;
   logic [2:0] trackSel_q, trackSel_d;
   logic [7:0] modeByte1_q, modeByte1_d;
   logic [7:0] modeByte2_q, modeByte2_d;
   logic [7:0] result_d;
   logic irq_d;
   logic modeLoad, memWrEn, anyReset;
   logic [7:0] memRdData;
   logic [3:0] settleN_q, settleN_d;

   assign anyReset = rst | softReset;

   always_comb
   begin
      state_d = state_q;
      cmd_d = cmd_q;
      argLeft_d = argLeft_q;
      argIdx_d = argIdx_q;
      trackWrite_d = trackWrite_q;
      trackSel_d = trackSel_q;
      modeByte1_d = modeByte1_q;
      modeByte2_d = modeByte2_q;
      result_d = resultByte_q;
      irq_d = irq_q;
      modeLoad = 1'b0;
      memWrEn = 1'b0;
      unique case (state_q)
         ST_IDLE:
         begin
            if (cmdWrite)
            begin
               argIdx_d = 2'h0;
               if (cmdByte == OPC_SENSE_DRIVE)
               begin
                  cmd_d = CMD_SENSE_DRIVE;
                  argLeft_d = ARGS_SENSE_DRIVE;
                  state_d = ST_ARG;
               end
               else if (cmdByte == OPC_MODE)
               begin
                  cmd_d = CMD_MODE;
                  argLeft_d = ARGS_MODE;
                  state_d = ST_ARG;
               end
               else if ({cmdByte[7], cmdByte[5:0]} == OPC_SET_TRACK)
               begin
                  cmd_d = CMD_SET_TRACK;
                  argLeft_d = ARGS_SET_TRACK;
                  trackWrite_d = cmdByte[SET_TRACK_RW_BIT];
                  state_d = ST_ARG;
               end
               else if (cmdByte == OPC_SENSE_INT && irq_q)
               begin
                  irq_d = 1'b0; // RULE_19
                  result_d = seekStatus0;
                  state_d = ST_RESULT;
               end
               else
               begin
                  // A status query with nothing pending is treated as undefined too.
                  result_d = ST0_INVALID; // RULE_17
                  state_d = ST_RESULT;
               end
            end
         end
         ST_ARG:
         begin
            if (cmdWrite)
            begin
               argIdx_d = argIdx_q + 2'h1;
               argLeft_d = argLeft_q - 2'h1;
               unique case (cmd_q)
                  CMD_SENSE_DRIVE:
                  begin
                     result_d = driveStatus3; // RULE_01
                     state_d = ST_RESULT;
                  end
                  CMD_MODE:
                  begin
                     if (argLeft_q == 2'h1)
                     begin
                        modeLoad = 1'b1;
                        state_d = ST_IDLE;
                     end
                     else if (argIdx_q == 2'h0)
                     begin
                        modeByte1_d = cmdByte;
                     end
                     else
                     begin
                        modeByte2_d = cmdByte;
                     end
                  end
                  CMD_SET_TRACK: // RULE_16
                  begin
                     if (argIdx_q == 2'h0)
                     begin
                        trackSel_d = cmdByte[2:0]; // RULE_14
                     end
                     else if (trackWrite_q)
                     begin
                        memWrEn = 1'b1; // RULE_13
                        result_d = cmdByte;
                        state_d = ST_RESULT;
                     end
                     else
                     begin
                        state_d = ST_LOOK; // RULE_12
                     end
                  end
                  default:
                  begin
                     state_d = ST_IDLE;
                  end
               endcase
            end
         end
         ST_LOOK:
         begin
            result_d = memRdData; // RULE_12
            state_d = ST_RESULT;
         end
         ST_RESULT:
         begin
            if (resultRead)
            begin
               state_d = ST_IDLE;
            end
         end
      endcase
      // A seek ending in the same cycle as the clearing query still leaves it pending.
      if (seekDone)
      begin
         irq_d = 1'b1; // RULE_19
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (anyReset)
      begin
         state_q <= ST_IDLE;
         cmd_q <= CMD_SENSE_DRIVE;
         argLeft_q <= 2'h0;
         argIdx_q <= 2'h0;
         trackWrite_q <= 1'b0;
         trackSel_q <= 3'h0;
         modeByte1_q <= 8'h00;
         modeByte2_q <= 8'h00;
         resultByte_q <= 8'h00;
         irq_q <= 1'b0;
         msrRqm_q <= 1'b1;
         msrDio_q <= 1'b0;
         msrBusy_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         argLeft_q <= argLeft_d;
         argIdx_q <= argIdx_d;
         trackWrite_q <= trackWrite_d;
         trackSel_q <= trackSel_d;
         modeByte1_q <= modeByte1_d;
         modeByte2_q <= modeByte2_d;
         resultByte_q <= result_d;
         irq_q <= irq_d;
         msrRqm_q <= (state_d != ST_LOOK); // RULE_18
         msrDio_q <= (state_d == ST_RESULT); // RULE_18
         msrBusy_q <= (state_d != ST_IDLE);
      end
   end

   fmtc_track_mem trackMem
   (
      .clk_sys(clk_sys),
      .wrEn(memWrEn),
      .wrAddr(trackSel_q),
      .wrData(cmdByte),
      .rdAddr(trackSel_q),
      .rdData_q(memRdData)
   );

   // ==========================================================
   // Mode settings, loaded together when the last mode byte arrives
   always_ff @(posedge clk_sys)
   begin
      if (anyReset)
      begin
         motorTimerScale_q <= 1'b0; // RULE_02
         lowPowerPolicy_q <= LP_DEFAULT;
         indexFieldOmit_q <= 1'b0;
         impliedSeekEnable_q <= 1'b0;
         extendedTrackRange_q <= 1'b0;
         scanWildcardDisable_q <= 1'b0;
         settleN_q <= SETTLE_DEFAULT;
         pumpPulseOutputEnable_q <= 1'b0;
         readGateTestEnable_q <= 1'b0;
      end
      else if (modeLoad)
      begin
         motorTimerScale_q <= modeByte1_q[MODE1_TIMER_SCALE]; // RULE_03
         lowPowerPolicy_q <= modeByte1_q[MODE1_LOW_POWER_LSB +: 2]; // RULE_04
         indexFieldOmit_q <= modeByte1_q[MODE1_INDEX_OMIT]; // RULE_05
         impliedSeekEnable_q <= modeByte1_q[MODE1_IMPLIED_SEEK]; // RULE_06
         extendedTrackRange_q <= modeByte2_q[MODE2_EXT_TRACK]; // RULE_07
         scanWildcardDisable_q <= modeByte2_q[MODE2_WILDCARD_DIS]; // RULE_08
         settleN_q <= modeByte2_q[MODE2_SETTLE_LSB +: 4]; // RULE_09
         pumpPulseOutputEnable_q <= cmdByte[MODE3_PUMP_PULSE]; // RULE_10
         readGateTestEnable_q <= cmdByte[MODE3_READ_GATE]; // RULE_11
      end
   end

   // ==========================================================
   // Head settle timer, counted in 4 ms units
   logic [4:0] settleUnits_q, settleUnits_d;
   logic [31:0] settleCnt_q, settleCnt_d;
   logic settleBusy_d;

   always_comb
   begin
      settleUnits_d = settleUnits_q;
      settleCnt_d = settleCnt_q;
      settleBusy_d = settleBusy_q;
      if (impliedSeekDone)
      begin
         settleUnits_d = rate250 ? {settleN_q, 1'b0} : {1'b0, settleN_q}; // RULE_09
         settleCnt_d = 32'h0;
         settleBusy_d = (settleN_q != 4'h0);
      end
      else if (settleBusy_q)
      begin
         if (settleCnt_q == 32'(SettleUnitCycles - 1))
         begin
            settleCnt_d = 32'h0;
            settleUnits_d = settleUnits_q - 5'h01;
            settleBusy_d = (settleUnits_q != 5'h01);
         end
         else
         begin
            settleCnt_d = settleCnt_q + 32'h1;
         end
      end
   end

   // ==========================================================
   // Low power entry; any new command wakes the controller.
   logic [31:0] lpCnt_q, lpCnt_d;
   logic lpArmed_q, lpArmed_d;
   logic lowPower_d;

   always_comb
   begin
      lpCnt_d = lpCnt_q;
      lpArmed_d = lpArmed_q;
      lowPower_d = lowPowerActive_q;
      if (cmdWrite || lowPowerPolicy_q == LP_OFF)
      begin
         lpArmed_d = 1'b0;
         lowPower_d = 1'b0;
      end
      else if (lowPowerPolicy_q == LP_NOW)
      begin
         lowPower_d = 1'b1; // RULE_04
      end
      else if (lowPowerPolicy_q == LP_AFTER_UNLOAD)
      begin
         if (headUnloadExpired && !lowPowerActive_q)
         begin
            lpArmed_d = 1'b1;
            lpCnt_d = 32'h0;
         end
         else if (lpArmed_q)
         begin
            lpCnt_d = lpCnt_q + 32'h1;
            if (lpCnt_q == 32'(LowPowerCycles - 1))
            begin
               lpArmed_d = 1'b0;
               lowPower_d = 1'b1; // RULE_04
            end
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (anyReset)
      begin
         settleUnits_q <= 5'h00;
         settleCnt_q <= 32'h0;
         settleBusy_q <= 1'b0;
         lpCnt_q <= 32'h0;
         lpArmed_q <= 1'b0;
         lowPowerActive_q <= 1'b0;
         seekFirst_q <= 1'b0;
         pumpPrecompPin_q <= 1'b0;
         readGate_q <= 1'b0;
         diskChange_q <= 1'b0;
      end
      else
      begin
         settleUnits_q <= settleUnits_d;
         settleCnt_q <= settleCnt_d;
         settleBusy_q <= settleBusy_d;
         lpCnt_q <= lpCnt_d;
         lpArmed_q <= lpArmed_d;
         lowPowerActive_q <= lowPower_d;
         seekFirst_q <= cmdImpliedSeekFlag & impliedSeekEnable_q; // RULE_06
         pumpPrecompPin_q <= pumpPulseOutputEnable_q ? pumpCorrection : precompEnable; // RULE_10
         readGate_q <= readGateTestEnable_q ? diskChangePin : internalReadGate; // RULE_11
         diskChange_q <= readGateTestEnable_q ? 1'b0 : diskChangePin; // RULE_11
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   invalid_result_a: assert property ((state_q == ST_IDLE) && cmdWrite && !softReset && cmdByte == 8'hFF // RULE_17
      |=> resultByte_q == ST0_INVALID && msrRqm_q && msrDio_q && state_q == ST_RESULT)
      else $error("undefined command did not give status 80h in result phase");
   invalid_no_irq_a: assert property ((state_q == ST_IDLE) && cmdWrite && !softReset && cmdByte == 8'hFF // RULE_18
      && !seekDone |=> irq_q == $past(irq_q))
      else $error("undefined command changed the interrupt");
   sense_drive_a: assert property ((state_q == ST_ARG) && cmd_q == CMD_SENSE_DRIVE && cmdWrite && !softReset // RULE_01
      |=> resultByte_q == $past(driveStatus3) && msrDio_q)
      else $error("drive status query returned wrong byte");
   seek_irq_hold_a: assert property (irq_q && !(state_q == ST_IDLE && cmdWrite && cmdByte == OPC_SENSE_INT) // RULE_19
      && !softReset |=> irq_q)
      else $error("seek interrupt cleared by something other than the status query");
   seek_irq_clear_a: assert property (irq_q && state_q == ST_IDLE && cmdWrite && cmdByte == OPC_SENSE_INT // RULE_19
      && !seekDone && !softReset |=> !irq_q ##0 resultByte_q == $past(seekStatus0))
      else $error("interrupt status query did not clear the seek interrupt");
   reset_defaults_a: assert property (softReset |=> !motorTimerScale_q && lowPowerPolicy_q == LP_DEFAULT // RULE_02
      && !impliedSeekEnable_q && !extendedTrackRange_q && !pumpPulseOutputEnable_q && !readGateTestEnable_q)
      else $error("mode settings not at defaults after reset");
   implied_seek_a: assert property (!$past(softReset) // RULE_06
      |-> seekFirst_q == $past(cmdImpliedSeekFlag && impliedSeekEnable_q))
      else $error("implied seek flag not gated by enable");
   pump_pin_a: assert property (pumpPulseOutputEnable_q && !softReset ##1 pumpPulseOutputEnable_q // RULE_10
      |-> pumpPrecompPin_q == $past(pumpCorrection))
      else $error("pump pulses not on shared pin");
   read_gate_a: assert property (readGateTestEnable_q && !softReset |=> readGate_q == $past(diskChangePin) // RULE_11
      && !diskChange_q)
      else $error("disk change pin not used as read gate");
   track_write_a: assert property ((state_q == ST_ARG) && cmd_q == CMD_SET_TRACK && argIdx_q == 2'h1 // RULE_13
      && trackWrite_q && cmdWrite && !softReset |=> resultByte_q == $past(cmdByte) && msrDio_q)
      else $error("track write did not echo the stored byte");
   track_read_a: assert property ((state_q == ST_ARG) && cmd_q == CMD_SET_TRACK && argIdx_q == 2'h1 // RULE_12
      && !trackWrite_q && cmdWrite && !softReset |=> !msrRqm_q ##1 msrDio_q && msrRqm_q)
      else $error("track read did not reach the result phase in two cycles");
   low_power_now_a: assert property (lowPowerPolicy_q == LP_NOW && !cmdWrite && !softReset // RULE_04
      |=> lowPowerActive_q)
      else $error("low power not entered at once");
   settle_zero_a: assert property (impliedSeekDone && settleN_q == 4'h0 && !softReset |=> !settleBusy_q) // RULE_09
      else $error("zero head settle time still busy");

   track_no_irq_a: assert property (cmd_q == CMD_SET_TRACK && state_q != ST_IDLE && !seekDone && !softReset // RULE_16
      |=> irq_q == $past(irq_q))
      else $error("track command changed the interrupt");

   mode_load_c: cover property (modeLoad);
   track_write_c: cover property (memWrEn);
   track_read_c: cover property (state_q == ST_LOOK);
   seek_clear_c: cover property (irq_q ##1 !irq_q);

endmodule // fmtc_core

`default_nettype wire

/* File: hdl/fmtc_pkg.sv */
// Overview of operation
// (RULE_01) Two-byte drive status query returns status register 3; no interrupt.
// (RULE_02) Hardware or software reset returns every mode setting to its default.
// (RULE_03) Motor timer scale 0 selects the short timer scale, 1 the long one.
// (RULE_04) Low power field: 00 off, 01 after unload plus 500 ms, 10 now.
// (RULE_05) Index field omit set drops the index address mark when formatting.
// (RULE_06) Implied seek flag of a command acts only when implied seek is enabled.
// (RULE_07) Extended track range gives 12-bit tracks, top nibble in head byte.
// (RULE_08) Scan treats FF as wildcard unless scan wildcard disable is set.
// (RULE_09) Head settle after implied seek is N times 4 ms, doubled at 250 kb/s.
// (RULE_10) Pump pulse enable routes charge pump corrections to the pump/precomp pin.
// (RULE_11) Read gate test enable makes the disk change pin an external read gate.
// (RULE_12) Track command read: result is the selected track byte, third byte ignored.
// (RULE_13) Track command write: third byte stored and echoed as the result.
// (RULE_14) Second byte bits 1..0 pick drive, bit 2 picks low or high track byte.
// (RULE_15) Host keeps byte select at 0 when extended track range is off.
// (RULE_16) Track command raises no interrupt.
// (RULE_17) Undefined command goes straight to result phase with status zero 80h.
// (RULE_18) Undefined command sets main status bits 6 and 7; no interrupt.
// (RULE_19) Only the interrupt status query clears a pending seek interrupt.
`default_nettype none

package fmtc_pkg;

   // ==========================================================
   // Command opcodes
   localparam logic [7:0] OPC_MODE = 8'h01;
   localparam logic [7:0] OPC_SENSE_DRIVE = 8'h04;
   localparam logic [7:0] OPC_SENSE_INT = 8'h08;
   localparam logic [6:0] OPC_SET_TRACK = 7'h21;
   localparam int SET_TRACK_RW_BIT = 6;
   localparam logic [7:0] ST0_INVALID = 8'h80;

   // ==========================================================
   // Argument counts per command
   localparam logic [1:0] ARGS_SENSE_DRIVE = 2'h1;
   localparam logic [1:0] ARGS_SET_TRACK = 2'h2;
   localparam logic [1:0] ARGS_MODE = 2'h3;

   // ==========================================================
   // Mode argument byte 1 fields
   localparam int MODE1_TIMER_SCALE = 0;
   localparam int MODE1_INDEX_OMIT = 1;
   localparam int MODE1_IMPLIED_SEEK = 2;
   localparam int MODE1_LOW_POWER_LSB = 4;
   // Mode argument byte 2 fields
   localparam int MODE2_EXT_TRACK = 0;
   localparam int MODE2_WILDCARD_DIS = 1;
   localparam int MODE2_SETTLE_LSB = 4;
   // Mode argument byte 3 fields
   localparam int MODE3_PUMP_PULSE = 0;
   localparam int MODE3_READ_GATE = 1;

   // ==========================================================
   // Track register select fields
   localparam int TRK_DRIVE_LSB = 0;
   localparam int TRK_BYTE_SEL = 2;

   // ==========================================================
   // Low power policy codes and mode defaults
   localparam logic [1:0] LP_OFF = 2'h0;
   localparam logic [1:0] LP_AFTER_UNLOAD = 2'h1;
   localparam logic [1:0] LP_NOW = 2'h2;
   localparam logic [1:0] LP_DEFAULT = LP_OFF;
   localparam logic [3:0] SETTLE_DEFAULT = 4'h0;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SETTLE_UNIT_MS = 4;
   localparam int LOW_POWER_DELAY_MS = 500;
   localparam int SETTLE_UNIT_CYCLES = SETTLE_UNIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int LOW_POWER_CYCLES = LOW_POWER_DELAY_MS * 1000000 / CLK_PERIOD_NS;

   // ==========================================================
   // Command sequencer states
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_ARG = 4'b0010,
      ST_LOOK = 4'b0100,
      ST_RESULT = 4'b1000
   } fmtc_state_type;

   typedef enum logic [1:0]
   {
      CMD_SENSE_DRIVE = 2'h0,
      CMD_MODE = 2'h1,
      CMD_SET_TRACK = 2'h2
   } fmtc_cmd_type;

endpackage : fmtc_pkg

`default_nettype wire

/* File: hdl/fmtc_track_mem.sv */
`default_nettype none

// ==========================================================
// Present track registers: low and high byte for each of four drives.
module fmtc_track_mem
(
   // Clock
   input wire logic clk_sys,
   // Write port
   input wire logic wrEn,
   input wire logic [2:0] wrAddr,
   input wire logic [7:0] wrData,
   // Read port, data registered
   input wire logic [2:0] rdAddr,
   output logic [7:0] rdData_q
);

   logic [7:0] mem [0:7];

   // Contents are not reset; the head position is unknown until the host sets it.
   always_ff @(posedge clk_sys)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData_q <= mem[rdAddr];
   end

endmodule // fmtc_track_mem

`default_nettype wire
